// File: logic/pfsm_consts.svh
`ifndef PFSM_CONSTS_SVH
`define PFSM_CONSTS_SVH

// Pin counts and the split between the two register sets.
`define PFSM_PIN_W          16
`define PFSM_SET0_HI        10
`define PFSM_SET1_LO        11
`define PFSM_SET0_N         11
`define PFSM_SET1_N         5

// Register byte offsets on the AXI4-Lite bus.
`define PFSM_ADDR_W         8
`define PFSM_OFF_FSEL0      8'h00
`define PFSM_OFF_FSEL1      8'h04
`define PFSM_OFF_MODE0      8'h08
`define PFSM_OFF_MODE1      8'h0C
`define PFSM_OFF_PINS       8'h10

// Field widths, positions and reset values.
`define PFSM_FSEL0_W        12
`define PFSM_FSEL1_W        5
`define PFSM_FSEL0_RESV     2
`define PFSM_FSEL0_RST      12'hFFF
`define PFSM_FSEL1_RST      5'h1F
`define PFSM_FSEL0_RDMASK   12'hFFB
`define PFSM_MODE_BIT       0
`define PFSM_MODE_RST       1'b0

// Pin carrying the counter terminal flag of counter 0.
`define PFSM_PIN_CTF        2

`endif

// File: logic/pfsm_mux.sv
// What this block does
// - Input pin level always reaches its general-purpose data bit.
// - Selected special-function input pin also feeds its peripheral module.
// - Unselected peripheral input is held inactive high.
// - Output pin driven by peripheral when selected, else by data register.
// - Select bit 1 means special function, default; 0 means general purpose.
// - Set 0 bits 11:8 select serial-peripheral functions on pins 10:7.
// - Set 0 bits 7:4 select serial channel data on pins 6:3.
// - Set 0 bit 3 selects counter terminal flag on pin 2.
// - Set 0 bits 1 and 0 select DMA ready on pins 1 and 0.
// - Set 1 bits 4:1 select channel 0 modem lines on pins 15:12.
// - Set 1 bit 0 selects EEPROM chip select on pin 11.
// - Mode bit of set 0 double-registers all set 0 pins.
// - Mode bit of set 1 double-registers all set 1 pins.
// - Mode bit 1 adds synchronisation; 0 keeps unsynchronised behaviour.
// - Direction bit 1 makes the pin an output, 0 an input.
`timescale 1ns/100ps
`include "pfsm_consts.svh"

module pfsm_mux
   import pfsm_pkg::*;
(
   input  wire logic                    clk_sys,        // System clock, 10 MHz.
   input  wire logic                    rst_n,          // Asynchronous reset, active low.
   input  wire logic [`PFSM_ADDR_W-1:0] s_axi_awaddr,   // Write address.
   input  wire logic                    s_axi_awvalid,  // Write address valid.
   output logic                         s_axi_awready,  // Write address ready.
   input  wire logic [31:0]             s_axi_wdata,    // Write data.
   input  wire logic [3:0]              s_axi_wstrb,    // Write byte strobes.
   input  wire logic                    s_axi_wvalid,   // Write data valid.
   output logic                         s_axi_wready,   // Write data ready.
   output logic [1:0]                   s_axi_bresp,    // Write answer code.
   output logic                         s_axi_bvalid,   // Write answer valid.
   input  wire logic                    s_axi_bready,   // Write answer ready.
   input  wire logic [`PFSM_ADDR_W-1:0] s_axi_araddr,   // Read address.
   input  wire logic                    s_axi_arvalid,  // Read address valid.
   output logic                         s_axi_arready,  // Read address ready.
   output logic [31:0]                  s_axi_rdata,    // Read data.
   output logic [1:0]                   s_axi_rresp,    // Read answer code.
   output logic                         s_axi_rvalid,   // Read answer valid.
   input  wire logic                    s_axi_rready,   // Read answer ready.
   input  wire logic [`PFSM_PIN_W-1:0]  pio_pin_i,      // Level seen on each pin.
   output logic      [`PFSM_PIN_W-1:0]  pio_pin_o,      // Level driven onto each pin.
   output logic      [`PFSM_PIN_W-1:0]  pio_pin_oe,     // Pin driver enable, high drives.
   input  wire logic [`PFSM_PIN_W-1:0]  pio_dir,        // Direction bits, 1 is output.
   input  wire logic [`PFSM_PIN_W-1:0]  gp_data_out,    // Data register bits for outputs.
   output logic      [`PFSM_PIN_W-1:0]  gp_data_in,     // Pin levels for the data register.
   input  wire logic [`PFSM_PIN_W-1:0]  periph_out,     // Peripheral drive, by pin index.
   output logic      [`PFSM_PIN_W-1:0]  periph_in       // Peripheral input, by pin index.
);
   // Register bus state.
   logic                    awready_ff;
   logic                    wready_ff;
   logic                    aw_held_ff;
   logic                    w_held_ff;
   logic [`PFSM_ADDR_W-1:0] awaddr_ff;
   logic [31:0]             wdata_ff;
   logic [3:0]              wstrb_ff;
   logic                    bvalid_ff;
   pfsm_resp_type           bresp_ff;
   logic                    arready_ff;
   logic                    rvalid_ff;
   pfsm_resp_type           rresp_ff;
   logic [31:0]             rdata_ff;
   // Configuration registers.
   logic [`PFSM_FSEL0_W-1:0] fsel0_ff;
   logic [`PFSM_FSEL1_W-1:0] fsel1_ff;
   pfsm_sync_type            mode0_ff;
   pfsm_sync_type            mode1_ff;
   // Pin side registers.
   logic [`PFSM_PIN_W-1:0] pin_o_ff;
   logic [`PFSM_PIN_W-1:0] pin_oe_ff;
   logic [`PFSM_PIN_W-1:0] gp_in_ff;
   logic [`PFSM_PIN_W-1:0] periph_in_ff;
   logic                   nxt_aw_held;
   logic                   nxt_w_held;
   logic                   nxt_rvalid;
   logic                   do_write;
   logic                   hit_fsel0;
   logic                   hit_fsel1;
   logic                   hit_mode0;
   logic                   hit_mode1;
   logic [`PFSM_PIN_W-1:0] sel_pin;
   logic [`PFSM_PIN_W-1:0] sync_q;
   logic [`PFSM_PIN_W-1:0] level;
   logic [31:0]            rd_word;
   logic                   rd_hit;
   // The write takes place once address and data are both held and no answer is pending.
   assign do_write    = aw_held_ff && w_held_ff && !bvalid_ff;
   assign nxt_aw_held = aw_held_ff ? !do_write : (s_axi_awvalid && awready_ff);
   assign nxt_w_held  = w_held_ff ? !do_write : (s_axi_wvalid && wready_ff);
   assign nxt_rvalid  = rvalid_ff ? !s_axi_rready : (s_axi_arvalid && arready_ff);
   assign hit_fsel0 = (awaddr_ff == `PFSM_OFF_FSEL0);
   assign hit_fsel1 = (awaddr_ff == `PFSM_OFF_FSEL1);
   assign hit_mode0 = (awaddr_ff == `PFSM_OFF_MODE0);
   assign hit_mode1 = (awaddr_ff == `PFSM_OFF_MODE1);
   // Address and data channels are taken independently, in either order.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         awaddr_ff  <= '0;
         wdata_ff   <= '0;
         wstrb_ff   <= '0;
      end
      else
      begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff  <= nxt_w_held;
         awready_ff <= !nxt_aw_held;
         wready_ff  <= !nxt_w_held;
         if (s_axi_awvalid && awready_ff)
            awaddr_ff <= s_axi_awaddr;
         if (s_axi_wvalid && wready_ff)
         begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
      end
   end

   // Write answer; an unmapped or read-only address answers with a slave error.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= PFSM_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (hit_fsel0 || hit_fsel1 || hit_mode0 || hit_mode1) ?
                      PFSM_RESP_OKAY : PFSM_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_ff <= 1'b0;
   end

   // Select registers reset to special function; reserved bits above the fields are dropped.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fsel0_ff <= `PFSM_FSEL0_RST;
         fsel1_ff <= `PFSM_FSEL1_RST;
      end
      else if (do_write)
      begin
         if (hit_fsel0 && wstrb_ff[0])
            fsel0_ff[7:0] <= wdata_ff[7:0];
         if (hit_fsel0 && wstrb_ff[1])
            fsel0_ff[11:8] <= wdata_ff[11:8];
         if (hit_fsel1 && wstrb_ff[0])
            fsel1_ff <= wdata_ff[`PFSM_FSEL1_W-1:0];
      end
   end

   // Mode bits start in the unsynchronised mode so that old software sees no extra delay.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode0_ff <= pfsm_sync_type'(`PFSM_MODE_RST);
         mode1_ff <= pfsm_sync_type'(`PFSM_MODE_RST);
      end
      else if (do_write && wstrb_ff[0])
      begin
         if (hit_mode0)
            mode0_ff <= pfsm_sync_type'(wdata_ff[`PFSM_MODE_BIT]);
         if (hit_mode1)
            mode1_ff <= pfsm_sync_type'(wdata_ff[`PFSM_MODE_BIT]);
      end
   end

   // Read decode; reserved bits read as zero.
   always_comb
   begin
      rd_word = '0;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         `PFSM_OFF_FSEL0: rd_word[`PFSM_FSEL0_W-1:0] = fsel0_ff & `PFSM_FSEL0_RDMASK;
         `PFSM_OFF_FSEL1: rd_word[`PFSM_FSEL1_W-1:0] = fsel1_ff;
         `PFSM_OFF_MODE0: rd_word[`PFSM_MODE_BIT]    = mode0_ff;
         `PFSM_OFF_MODE1: rd_word[`PFSM_MODE_BIT]    = mode1_ff;
         `PFSM_OFF_PINS:  rd_word[`PFSM_PIN_W-1:0]   = gp_in_ff;
         default:         rd_hit                     = 1'b0;
      endcase
   end

   // Read channel; the answer follows one cycle after the address is taken.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
         rdata_ff   <= '0;
         rresp_ff   <= PFSM_RESP_OKAY;
      end
      else
      begin
         rvalid_ff  <= nxt_rvalid;
         arready_ff <= !nxt_rvalid;
         if (s_axi_arvalid && arready_ff)
         begin
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? PFSM_RESP_OKAY : PFSM_RESP_SLVERR;
         end
      end
   end

   // Per-pin select, in pin order; select bit 2 of set 0 is reserved and skipped.
   assign sel_pin = {fsel1_ff, fsel0_ff[11:3], fsel0_ff[1:0]};

   // One synchroniser always runs for all pins, so a mode switch needs no refill time.
   pfsm_sync2 #(.W (`PFSM_PIN_W)) u_sync
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (pio_pin_i),
      .q       (sync_q)
   );
   // Each set picks raw or double-registered levels as a whole group.
   assign level[`PFSM_SET0_HI:0] = (mode0_ff == PFSM_SYNC_DOUBLE) ? sync_q[`PFSM_SET0_HI:0] :
                                   pio_pin_i[`PFSM_SET0_HI:0];
   assign level[`PFSM_PIN_W-1:`PFSM_SET1_LO] = (mode1_ff == PFSM_SYNC_DOUBLE) ?
                                              sync_q[`PFSM_PIN_W-1:`PFSM_SET1_LO] :
                                              pio_pin_i[`PFSM_PIN_W-1:`PFSM_SET1_LO];

   // Inbound path: the data bit always sees the pin, the peripheral only when selected.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gp_in_ff     <= '0;
         periph_in_ff <= '1;
      end
      else
      begin
         gp_in_ff     <= level;
         periph_in_ff <= level | ~(sel_pin & ~pio_dir);
      end
   end

   // Outbound path: value chosen by select, driver enabled by direction only.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_o_ff  <= '0;
         pin_oe_ff <= '0;
      end
      else
      begin
         pin_o_ff  <= (sel_pin & periph_out) | (~sel_pin & gp_data_out);
         pin_oe_ff <= pio_dir;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;
   assign pio_pin_o     = pin_o_ff;
   assign pio_pin_oe    = pin_oe_ff;
   assign gp_data_in    = gp_in_ff;
   assign periph_in     = periph_in_ff;

   // Checks on the pin paths and the register bus.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_gp_direct;
      $past(rst_n) && $past(mode0_ff == PFSM_SYNC_BYPASS)
      |-> gp_in_ff[`PFSM_SET0_HI:0] == $past(pio_pin_i[`PFSM_SET0_HI:0]);
   endproperty
   a_gp_direct: assert property (p_gp_direct) else $error("set 0 direct path wrong");
   property p_gp_sync1;
      $past(rst_n, 3) && $past(mode1_ff == PFSM_SYNC_DOUBLE)
      |-> gp_in_ff[15:11] == $past(pio_pin_i[15:11], 3);
   endproperty
   a_gp_sync1: assert property (p_gp_sync1) else $error("set 1 sync delay wrong");
   property p_gp_sync0;
      $past(rst_n, 3) && $past(mode0_ff == PFSM_SYNC_DOUBLE)
      |-> gp_in_ff[10:0] == $past(pio_pin_i[10:0], 3);
   endproperty
   a_gp_sync0: assert property (p_gp_sync0) else $error("set 0 sync delay wrong");
   property p_periph_follow;
      $past(rst_n) |-> ((periph_in_ff ^ gp_in_ff) & $past(sel_pin & ~pio_dir)) == '0;
   endproperty
   a_periph_follow: assert property (p_periph_follow) else $error("peripheral input wrong");
   property p_periph_idle;
      $past(rst_n) |-> &(periph_in_ff | $past(sel_pin & ~pio_dir));
   endproperty
   a_periph_idle: assert property (p_periph_idle) else $error("unselected input not high");
   property p_out_source;
      $past(rst_n)
      |-> pin_o_ff == $past((sel_pin & periph_out) | (~sel_pin & gp_data_out));
   endproperty
   a_out_source: assert property (p_out_source) else $error("pin output source wrong");
   property p_oe_dir;
      $past(rst_n) |-> pin_oe_ff == $past(pio_dir);
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("driver enable wrong");
   property p_fsel1_write;
      $rose(bvalid_ff) && $past(hit_fsel1 && wstrb_ff[0])
      |-> fsel1_ff == $past(wdata_ff[4:0]);
   endproperty
   a_fsel1_write: assert property (p_fsel1_write) else $error("select set 1 not stored");
   property p_mode0_write;
      $rose(bvalid_ff) && $past(hit_mode0 && wstrb_ff[0])
      |-> mode0_ff == $past(wdata_ff[0]);
   endproperty
   a_mode0_write: assert property (p_mode0_write) else $error("mode 0 not stored");
   property p_bvalid_hold;
      bvalid_ff && !s_axi_bready |=> bvalid_ff;
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_special_out: cover property (pin_oe_ff[`PFSM_PIN_CTF] && sel_pin[`PFSM_PIN_CTF]);
   c_sync_mode: cover property (mode0_ff == PFSM_SYNC_DOUBLE && mode1_ff == PFSM_SYNC_DOUBLE);

endmodule // pfsm_mux

// File: logic/pfsm_pkg.sv
package pfsm_pkg;

   // Write and read answer codes used on the register bus.
   typedef enum logic [1:0]
   {
      PFSM_RESP_OKAY   = 2'b00,
      PFSM_RESP_SLVERR = 2'b10
   } pfsm_resp_type;

   // Whether an input set is passed straight through or double registered.
   typedef enum logic
   {
      PFSM_SYNC_BYPASS = 1'b0,
      PFSM_SYNC_DOUBLE = 1'b1
   } pfsm_sync_type;

endpackage

// File: logic/pfsm_sync2.sv
`timescale 1ns/100ps

// Two-stage synchroniser for a group of pin inputs.
module pfsm_sync2
#(
   parameter int W = 16
)
(
   input  wire logic         clk_sys,  // System clock.
   input  wire logic         rst_n,    // Asynchronous reset, active low.
   input  wire logic [W-1:0] d,        // Raw pin levels.
   output logic      [W-1:0] q         // Levels after two flops.
);

   logic [W-1:0] meta_ff;

   // The first stage is read only by the second, so a metastable value never fans out.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_ff <= '0;
         q       <= '0;
      end
      else
      begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule // pfsm_sync2

// File: tb/pfsm_far_end.sv
`timescale 1ns/100ps
`include "pfsm_consts.svh"

// Far side of the mux: the board wired to each pin and the peripherals behind it.
module pfsm_far_end
(
   input  wire logic [`PFSM_PIN_W-1:0] pio_pin_o,   // Level the device drives.
   input  wire logic [`PFSM_PIN_W-1:0] pio_pin_oe,  // Device driver enable, high drives.
   input  wire logic [`PFSM_PIN_W-1:0] ext_level,   // Level the board drives when free.
   input  wire logic [`PFSM_PIN_W-1:0] per_level,   // Levels the peripherals present.
   output logic      [`PFSM_PIN_W-1:0] pio_pin_i,   // Resolved level on each pin.
   output logic      [`PFSM_PIN_W-1:0] periph_out   // Peripheral drive per pin.
);
   // The board backs off wherever the device drives, so the wire never sees a fight.
   assign pio_pin_i = (pio_pin_oe & pio_pin_o) | (~pio_pin_oe & ext_level);

   // Peripherals present their drive whether or not their pin is routed to them.
   assign periph_out = per_level;
endmodule // pfsm_far_end

// File: tb/testbench.sv
`timescale 1ns/100ps
`include "pfsm_consts.svh"

module testbench
   import pfsm_pkg::*;
;
   logic        clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, w;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] pio_pin_i, pio_pin_o, pio_pin_oe, pio_dir, gp_data_out, gp_data_in;
   logic [15:0] periph_out, periph_in, ext_level, per_level, exp_gp;
   int          bad_count, n_checks, seed, sel0, sel1;

   pfsm_mux pfsm_mux_inst
   (
      .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pio_pin_i, .pio_pin_o, .pio_pin_oe,
      .pio_dir, .gp_data_out, .gp_data_in, .periph_out, .periph_in
   );

   pfsm_far_end pfsm_far_end_inst
   (
      .pio_pin_o, .pio_pin_oe, .ext_level, .per_level, .pio_pin_i, .periph_out
   );

   // Free-running system clock, 100 ns period.
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Select bit of the model that governs a pin.
   function automatic int selb(int p);
      if (p < 2)
         return (sel0 >> p) & 1;
      if (p < 11)
         return (sel0 >> (p + 1)) & 1;
      return (sel1 >> (p - 11)) & 1;
   endfunction

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Comparison against the model once the pins have settled; pio_pin_o only on pins with pio_dir set.
   task automatic check_pins();
      logic [15:0] eo;
      logic [15:0] ep;
      for (int p = 0; p < 16; p++)
      begin
         eo[p] = selb(p) ? per_level[p] : gp_data_out[p];
         exp_gp[p] = pio_dir[p] ? eo[p] : ext_level[p];
         ep[p] = (selb(p) == 1 && !pio_dir[p]) ? exp_gp[p] : 1'b1;
      end
      chk("pio_pin_oe", 32'(pio_dir), 32'(pio_pin_oe));
      chk("pio_pin_o", 32'(eo & pio_dir), 32'(pio_pin_o & pio_dir));
      chk("gp_data_in", 32'(exp_gp), 32'(gp_data_in));
      chk("periph_in", 32'(ep), 32'(periph_in));
   endtask

   // Six edges cover the slowest path: output register, then three input stages.
   task automatic settle();
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      check_pins();
   endtask

   // Write with address and data offered together; each is released once taken.
   task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
      logic aw_p;
      logic w_p;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_p = 1'b1;
      w_p = 1'b1;
      while (aw_p || w_p || s_axi_bvalid !== 1'b1)
      begin
         @(posedge clk_sys);
         if (aw_p && s_axi_awready === 1'b1)
         begin
            aw_p = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_p && s_axi_wready === 1'b1)
         begin
            w_p = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask

   task automatic axi_rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
         @(posedge clk_sys);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do
         @(posedge clk_sys);
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
   endtask

   // A step on every input pin, timed edge by edge in the given mode.
   task automatic lat(int m);
      axi_wr(`PFSM_OFF_MODE0, 32'(m), PFSM_RESP_OKAY);
      axi_wr(`PFSM_OFF_MODE1, 32'(m), PFSM_RESP_OKAY);
      @(posedge clk_sys);
      pio_dir <= 16'h0000;
      ext_level <= 16'h0000;
      repeat (6) @(posedge clk_sys);
      ext_level <= 16'hFFFF;
      for (int k = 1; k < 4; k++)
      begin
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk("gp_data_in", (m == 1 && k < 3) ? 32'h0000_0000 : 32'h0000_FFFF,
             32'(gp_data_in));
      end
      $display("test latency mode %0d done", m);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // The whole run needs well under two thousand cycles; twenty thousand means a hang.
   initial
   begin
      #(100 * 20000);
      bad_count++;
      tally_and_finish();
   end

   // Main sequence.
   initial
   begin
      seed = 32'h0000_D409;
      rst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      pio_dir = 16'h0000;
      gp_data_out = 16'($random(seed));
      ext_level = 16'($random(seed));
      per_level = 16'($random(seed));
      sel0 = 32'h0000_0FFB;
      sel1 = 32'h0000_001F;
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("periph_in", 32'h0000_FFFF, 32'(periph_in));
      chk("pio_pin_oe", 32'h0000_0000, 32'(pio_pin_oe));
      @(posedge clk_sys);
      rst_n <= 1'b1;
      axi_rd(`PFSM_OFF_FSEL0, 32'h0000_0FFB, PFSM_RESP_OKAY);
      axi_rd(`PFSM_OFF_FSEL1, 32'h0000_001F, PFSM_RESP_OKAY);
      axi_rd(`PFSM_OFF_MODE0, 32'h0000_0000, PFSM_RESP_OKAY);
      axi_rd(`PFSM_OFF_MODE1, 32'h0000_0000, PFSM_RESP_OKAY);
      settle();
      $display("test defaults done");
      axi_rd(8'h20, 32'h0000_0000, PFSM_RESP_SLVERR);
      axi_wr(`PFSM_OFF_PINS, 32'h0000_FFFF, PFSM_RESP_SLVERR);
      axi_wr(8'h40, 32'h0000_0000, PFSM_RESP_SLVERR);
      axi_rd(`PFSM_OFF_FSEL0, 32'h0000_0FFB, PFSM_RESP_OKAY);
      s_axi_wstrb <= 4'h1;
      axi_wr(`PFSM_OFF_FSEL0, 32'hFFFF_F004, PFSM_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      axi_rd(`PFSM_OFF_FSEL0, 32'h0000_0F00, PFSM_RESP_OKAY);
      $display("test bus errors done");
      for (int i = 0; i < 30; i++)
      begin
         w = $random(seed);
         axi_wr(`PFSM_OFF_FSEL0, w | 32'hFFFF_F004, PFSM_RESP_OKAY);
         sel0 = w & 32'h0000_0FFB;
         axi_rd(`PFSM_OFF_FSEL0, sel0, PFSM_RESP_OKAY);
         w = $random(seed);
         axi_wr(`PFSM_OFF_FSEL1, w | 32'hFFFF_FFE0, PFSM_RESP_OKAY);
         sel1 = w & 32'h0000_001F;
         axi_rd(`PFSM_OFF_FSEL1, sel1, PFSM_RESP_OKAY);
         axi_wr(`PFSM_OFF_MODE0, 32'(i % 2), PFSM_RESP_OKAY);
         axi_wr(`PFSM_OFF_MODE1, 32'((i / 2) % 2), PFSM_RESP_OKAY);
         axi_rd(`PFSM_OFF_MODE1, 32'((i / 2) % 2), PFSM_RESP_OKAY);
         @(posedge clk_sys);
         pio_dir <= 16'($random(seed));
         gp_data_out <= 16'($random(seed));
         ext_level <= 16'($random(seed));
         per_level <= 16'($random(seed));
         settle();
         axi_rd(`PFSM_OFF_PINS, 32'(exp_gp), PFSM_RESP_OKAY);
      end
      $display("test random routing done");
      lat(0);
      lat(1);
      tally_and_finish();
   end
endmodule // testbench
